/* File: hw/bst_map.vh */
// Constants for the boundary-scan test access port
`ifndef BST_MAP_VH
`define BST_MAP_VH
// Controller states
`define BST_ST_RESET   4'h0
`define BST_ST_IDLE    4'h1
`define BST_ST_SEL_DR  4'h2
`define BST_ST_CAP_DR  4'h3
`define BST_ST_SH_DR   4'h4
`define BST_ST_EX1_DR  4'h5
`define BST_ST_PAU_DR  4'h6
`define BST_ST_EX2_DR  4'h7
`define BST_ST_UPD_DR  4'h8
`define BST_ST_SEL_IR  4'h9
`define BST_ST_CAP_IR  4'ha
`define BST_ST_SH_IR   4'hb
`define BST_ST_EX1_IR  4'hc
`define BST_ST_PAU_IR  4'hd
`define BST_ST_EX2_IR  4'he
`define BST_ST_UPD_IR  4'hf
// Instruction width and capture pattern of the low two bits
`define BST_IR_W       3
`define BST_IR_CAP     2'h1
// Default opcode table
`define BST_OP_EXTEST  3'h0
`define BST_OP_IDCODE  3'h1
`define BST_OP_SAMPZ   3'h2
`define BST_OP_SAMPLE  3'h4
`define BST_OP_BYPASS  3'h7
// Identification register width
`define BST_ID_W       32
// Mode-select high edges that reach reset from any state
`define BST_RST_EDGES  5
`endif

/* File: hw/bst_sync.v */
// Two-flop synchroniser for test-port pins
`timescale 1ns/1ps
module bst_sync #(
   parameter W   = 1,
   parameter INI = 1'b0
) (
   input  wire         mclk_i,
   input  wire         rst_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // First stage is read only by the second stage
   always @(posedge mclk_i) begin
      if (rst_i) begin
         meta_reg <= {W{INI}};
         sync_reg <= {W{INI}};
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule // bst_sync

/* File: hw/bst_tap.v */
// Boundary-scan test access port: controller, instruction, bypass, ID and boundary registers
`timescale 1ns/1ps
`include "bst_map.vh"

// Functional notes
// - Inputs taken on rising test clock; serial output and its enable change on falling test clock.
// - Mode-select and serial input read as one when left unconnected.
// - Serial input enters register MSB; register LSB drives serial output.
// - Current instruction picks exactly one register between serial in and out.
// - Serial output driver enabled only in shift states, else high impedance.
// - Five rising edges with mode-select high reset controller; memory unaffected.
// - Power-up resets controller internally; serial output starts high impedance.
// - Three-bit instruction register loaded serially in instruction shift state.
// - Instruction becomes identification read at power-up and on controller reset.
// - Instruction capture loads low two bits with pattern 01.
// - One-bit bypass register can sit between serial in and out.
// - Bypass instruction clears the bypass register to zero.
// - Boundary register holds one cell per input and bidirectional ball.
// - Data capture loads boundary register from ring; data shift shifts it.
// - Extest, sample/preload and sample-Z capture the ring contents.
// - Identification instruction captures fixed 32-bit code and shifts it out.
// - Sample-Z connects boundary register and holds output bus high impedance.
module bst_tap #(
   parameter BSR_W     = 8,
   parameter [31:0] ID_CODE = 32'h0000_0001,   // Arbitrary value
   parameter [2:0] OP_EXTEST = `BST_OP_EXTEST,
   parameter [2:0] OP_IDCODE = `BST_OP_IDCODE,
   parameter [2:0] OP_SAMPZ  = `BST_OP_SAMPZ,
   parameter [2:0] OP_SAMPLE = `BST_OP_SAMPLE,
   parameter [2:0] OP_BYPASS = `BST_OP_BYPASS,
   parameter OZ_BIT    = BSR_W-1
) (
   input  wire             mclk_i,
   input  wire             rst_i,
   input  wire             tck_i,
   input  wire             tms_i,
   input  wire             tms_pull_i,
   input  wire             tdi_i,
   input  wire             tdi_pull_i,
   output wire             tdo_o,
   output wire             tdo_oe_n_o,
   input  wire [BSR_W-1:0] ring_i,
   output wire [BSR_W-1:0] preload_o,
   output wire             extest_o,
   output wire             out_bus_hiz_o,
   output wire [3:0]       tap_state_o
);
   wire [2:0]       pin_s;
   wire             tck_s;
   wire             tms_s;
   wire             tdi_s;
   reg              tck_d_reg;
   reg  [3:0]       st_reg;
   reg  [3:0]       st_next;
   reg  [2:0]       ir_sh_reg;
   reg  [2:0]       ir_reg;
   reg              byp_reg;
   reg  [31:0]      id_reg;
   reg  [BSR_W-1:0] bsr_reg;   // One cell per input or two-way ball
   reg  [BSR_W-1:0] pre_reg;
   reg  [2:0]       tms_cnt_reg;
   reg              tdo_reg;
   reg              tdo_oe_n_reg;
   reg              sel_bsr;
   reg              sel_id;
   reg              sel_byp;
   reg              ser_out;
   wire             rise;
   wire             fall;
   wire [BSR_W-1:0] ring_s;
   wire             rst_run;
   wire             go_rst;

   // Pins cross into mclk; a floating mode-select or serial input pin reads high through its pull
   bst_sync #(.W(3), .INI(1'b0)) u_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .d_i    ({tck_i, tms_i | tms_pull_i, tdi_i | tdi_pull_i}),
      .q_o    (pin_s)
   );
   assign tck_s = pin_s[2];
   assign tms_s = pin_s[1];
   assign tdi_s = pin_s[0];

   // Ring runs on the memory clock; each cell is its own ball, so skew between
   // bits only matches the snapshot uncertainty a moving ball has anyway
   bst_sync #(.W(BSR_W), .INI(1'b0)) u_ring_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .d_i    (ring_i),
      .q_o    (ring_s)
   );

   // Edge finder on the synchronised test clock
   always @(posedge mclk_i) begin
      if (rst_i)
         tck_d_reg <= 1'b0;
      else
         tck_d_reg <= tck_s;
   end
   assign rise = tck_s & ~tck_d_reg;
   assign fall = ~tck_s & tck_d_reg;

   // Standard next-state table
   always @* begin
      case (st_reg)
         `BST_ST_RESET:  st_next = tms_s ? `BST_ST_RESET  : `BST_ST_IDLE;
         `BST_ST_IDLE:   st_next = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
         `BST_ST_SEL_DR: st_next = tms_s ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
         `BST_ST_CAP_DR: st_next = tms_s ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
         `BST_ST_SH_DR:  st_next = tms_s ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
         `BST_ST_EX1_DR: st_next = tms_s ? `BST_ST_UPD_DR : `BST_ST_PAU_DR;
         `BST_ST_PAU_DR: st_next = tms_s ? `BST_ST_EX2_DR : `BST_ST_PAU_DR;
         `BST_ST_EX2_DR: st_next = tms_s ? `BST_ST_UPD_DR : `BST_ST_SH_DR;
         `BST_ST_UPD_DR: st_next = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
         `BST_ST_SEL_IR: st_next = tms_s ? `BST_ST_RESET  : `BST_ST_CAP_IR;
         `BST_ST_CAP_IR: st_next = tms_s ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
         `BST_ST_SH_IR:  st_next = tms_s ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
         `BST_ST_EX1_IR: st_next = tms_s ? `BST_ST_UPD_IR : `BST_ST_PAU_IR;
         `BST_ST_PAU_IR: st_next = tms_s ? `BST_ST_EX2_IR : `BST_ST_PAU_IR;
         `BST_ST_EX2_IR: st_next = tms_s ? `BST_ST_UPD_IR : `BST_ST_SH_IR;
         `BST_ST_UPD_IR: st_next = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
         default:        st_next = `BST_ST_RESET;
      endcase
   end

   // Run-of-ones counter; the state table alone reaches reset in five, this
   // forces it anyway so a corrupted state cannot escape
   always @(posedge mclk_i) begin
      if (rst_i)
         tms_cnt_reg <= 3'h0;
      else if (rise)
         tms_cnt_reg <= tms_s ? ((tms_cnt_reg == 3'h7) ? 3'h7 : tms_cnt_reg + 3'h1) : 3'h0;
   end

   // Reset entry is seen on the edge that enters it, so the default
   // instruction is already current while the controller sits in reset
   assign rst_run = tms_s & (tms_cnt_reg >= 3'h4);   // Fifth high edge
   assign go_rst  = rise & (rst_run | (st_next == `BST_ST_RESET));

   // Controller state; system reset stands for power-up
   always @(posedge mclk_i) begin
      if (rst_i)
         st_reg <= `BST_ST_RESET;
      else if (rise) begin
         if (rst_run)
            st_reg <= `BST_ST_RESET;
         else
            st_reg <= st_next;
      end
   end

   // Decode; anything not in the table falls to bypass
   always @* begin
      sel_bsr = (ir_reg == OP_EXTEST) | (ir_reg == OP_SAMPLE) | (ir_reg == OP_SAMPZ);
      sel_id  = (ir_reg == OP_IDCODE);
      sel_byp = ~sel_bsr & ~sel_id;
   end

   // Instruction path: capture 01, shift from MSB, update, reset to ID
   always @(posedge mclk_i) begin
      if (rst_i) begin
         ir_sh_reg <= 3'h0;
         ir_reg    <= OP_IDCODE;
      end else if (rise) begin
         if (st_reg == `BST_ST_RESET || go_rst)
            ir_reg <= OP_IDCODE;
         else if (st_reg == `BST_ST_UPD_IR)
            ir_reg <= ir_sh_reg;
         if (st_reg == `BST_ST_CAP_IR)
            ir_sh_reg <= {1'b0, `BST_IR_CAP};
         else if (st_reg == `BST_ST_SH_IR)
            ir_sh_reg <= {tdi_s, ir_sh_reg[2:1]};
      end
   end

   // Data registers; only the selected one captures or shifts
   always @(posedge mclk_i) begin
      if (rst_i) begin
         byp_reg <= 1'b0;
         id_reg  <= 32'h0;
         bsr_reg <= {BSR_W{1'b0}};
      end else if (rise) begin
         if (st_reg == `BST_ST_CAP_DR) begin
            if (sel_byp)
               byp_reg <= 1'b0;
            if (sel_id)
               id_reg <= ID_CODE;
            if (sel_bsr)
               bsr_reg <= ring_s;
         end else if (st_reg == `BST_ST_SH_DR) begin
            if (sel_byp)
               byp_reg <= tdi_s;
            if (sel_id)
               id_reg <= {tdi_s, id_reg[31:1]};
            if (sel_bsr)
               bsr_reg <= {tdi_s, bsr_reg[BSR_W-1:1]};
         end
      end
   end

   // Preload latches; output-enable cell preset high on reset
   always @(posedge mclk_i) begin
      if (rst_i)
         pre_reg <= {BSR_W{1'b0}} | ({{(BSR_W-1){1'b0}}, 1'b1} << OZ_BIT);
      else if (rise) begin
         if (st_reg == `BST_ST_RESET || go_rst)
            pre_reg[OZ_BIT] <= 1'b1;
         else if (st_reg == `BST_ST_UPD_DR && sel_bsr)
            pre_reg <= bsr_reg;
      end
   end

   // Serial output mux picks the LSB of the one path in use
   always @* begin
      if (st_reg == `BST_ST_SH_IR)
         ser_out = ir_sh_reg[0];
      else if (sel_bsr)
         ser_out = bsr_reg[0];
      else if (sel_id)
         ser_out = id_reg[0];
      else
         ser_out = byp_reg;
   end

   // Output stage moves only on the falling edge
   always @(posedge mclk_i) begin
      if (rst_i) begin
         tdo_reg      <= 1'b0;
         tdo_oe_n_reg <= 1'b1;
      end else if (fall) begin
         tdo_reg      <= ser_out;
         tdo_oe_n_reg <= ~(st_reg == `BST_ST_SH_DR || st_reg == `BST_ST_SH_IR);
      end
   end

   assign tdo_o         = tdo_reg;
   assign tdo_oe_n_o    = tdo_oe_n_reg;
   assign preload_o     = pre_reg;
   assign extest_o      = (ir_reg == OP_EXTEST);
   // Memory bus forced off under sample-Z, or by the extest cell
   assign out_bus_hiz_o = (ir_reg == OP_SAMPZ) | ((ir_reg == OP_EXTEST) & ~pre_reg[OZ_BIT]);
   assign tap_state_o   = st_reg;
endmodule // bst_tap

/* File: tb/bst_ctl_model.sv */
// Scan controller model driving test clock, mode-select and serial input
`timescale 1ns/1ps
module bst_ctl_model (
   input  wire  mclk_i,
   input  wire  tdo_i,
   input  wire  tdo_oe_n_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   // Clock rests low between frames
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   // One 8 mclk period; inputs set 3 mclk before the rise, output read at it
   task automatic step(input logic ms, input logic di, output logic do_v, output logic oe_n);
      @(negedge mclk_i);
      tms_o = ms;
      tdi_o = di;
      repeat (3) @(negedge mclk_i);
      // A released output reads as the inverse so a stray sample is caught
      do_v = tdo_oe_n_i ? ~tdo_i : tdo_i;
      oe_n = tdo_oe_n_i;
      tck_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      tck_o = 1'b0;
   endtask
endmodule // bst_ctl_model

/* File: tb/bst_tap_chk.sv */
// Assertion checker for the test access port
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap_chk #(
   parameter BSR_W  = 8,
   parameter OZ_BIT = BSR_W-1
) (
   input wire       mclk_i,
   input wire       rst_i,
   input wire       tck_i,
   input wire       tms_i,
   input wire       tms_pull_i,
   input wire [3:0] tap_state_o,
   input wire       tdo_o,
   input wire       tdo_oe_n_o,
   input wire       extest_o,
   input wire       out_bus_hiz_o
);
   logic       tck_d;
   logic [2:0] hi_cnt;
   // Run of rises with mode-select high; a floating pin counts as high
   always @(posedge mclk_i) begin
      tck_d <= tck_i;
      if (rst_i) hi_cnt <= 3'h0;
      else if (tck_i && !tck_d) hi_cnt <= !(tms_i | tms_pull_i) ? 3'h0 : (hi_cnt + {2'h0, hi_cnt != 3'h5});
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_rst_run; hi_cnt == 3'h5 |-> ##[0:6] tap_state_o == `BST_ST_RESET; endproperty
   a_rst_run: assert property (p_rst_run) else $error("no reset after five high rises");
   property p_st_rise; $changed(tap_state_o) |-> tck_i; endproperty
   a_st_rise: assert property (p_st_rise) else $error("state moved with clock low");
   property p_tdo_fall; $changed({tdo_o, tdo_oe_n_o}) |-> !tck_i; endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("output moved with clock high");
   property p_oe_on; $fell(tdo_oe_n_o) |-> tap_state_o inside {`BST_ST_SH_DR, `BST_ST_SH_IR}; endproperty
   a_oe_on: assert property (p_oe_on) else $error("driver on outside shift");
   property p_oe_off; !(tap_state_o inside {4'h4, 4'h5, 4'hb, 4'hc}) |-> tdo_oe_n_o; endproperty
   a_oe_off: assert property (p_oe_off) else $error("driver on in idle state");
   property p_ir_rst; tap_state_o == 4'h0 && $past(tap_state_o) == 4'h0 |-> !extest_o && !out_bus_hiz_o; endproperty
   a_ir_rst: assert property (p_ir_rst) else $error("instruction not default in reset");
   property p_ir_hold; $changed(extest_o) |-> tap_state_o inside {4'hf, 4'h1, 4'h2, 4'h0}; endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("instruction changed outside update");
   property p_hiz_hold; $changed(out_bus_hiz_o) && !extest_o && !$past(extest_o) |-> tap_state_o inside {4'hf, 4'h1, 4'h2, 4'h0}; endproperty
   a_hiz_hold: assert property (p_hiz_hold) else $error("bus float changed outside update");
endmodule // bst_tap_chk
bind bst_tap bst_tap_chk #(.BSR_W(BSR_W), .OZ_BIT(OZ_BIT)) chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
   .tck_i(tck_i), .tms_i(tms_i), .tms_pull_i(tms_pull_i), .tap_state_o(tap_state_o), .tdo_o(tdo_o),
   .tdo_oe_n_o(tdo_oe_n_o), .extest_o(extest_o), .out_bus_hiz_o(out_bus_hiz_o));

/* File: tb/sram_boundary_scan_tap_tb_top.sv */
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "bst_map.vh"
module sram_boundary_scan_tap_tb_top;
   logic        mclk_i = 1'b0, rst_i = 1'b1, tms_pull = 1'b0, tdi_pull = 1'b0;
   logic        tck, tms, tdi, tdo, oe_n, extest, hiz, o, e;
   logic [7:0]  ring = 8'h00;
   logic [7:0]  preload;
   logic [3:0]  state;
   logic [31:0] d;
   int          fail_count = 0;
   int          checked = 0;
   initial forever #50 mclk_i = ~mclk_i;
   bst_tap dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tms_pull_i(tms_pull),
      .tdi_i(tdi), .tdi_pull_i(tdi_pull), .tdo_o(tdo), .tdo_oe_n_o(oe_n), .ring_i(ring),
      .preload_o(preload), .extest_o(extest), .out_bus_hiz_o(hiz), .tap_state_o(state));
   bst_ctl_model ctl_u (.mclk_i(mclk_i), .tdo_i(tdo), .tdo_oe_n_i(oe_n), .tck_o(tck), .tms_o(tms),
      .tdi_o(tdi));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results;
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Idle to shift, n bits LSB first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] q);
      q = 32'h0;
      ctl_u.step(1'b1, 1'b1, o, e);
      if (ir) ctl_u.step(1'b1, 1'b1, o, e);
      ctl_u.step(1'b0, 1'b1, o, e);
      ctl_u.step(1'b0, 1'b1, o, e);
      for (int i = 0; i < n; i++) begin
         ctl_u.step(i == n - 1, din[i], o, e);
         q[i] = o;
         chk("driver enable", 1'b0, e);
      end
      ctl_u.step(1'b1, 1'b1, o, e);
      ctl_u.step(1'b0, 1'b1, o, e);
      chk("idle enable", 1'b1, oe_n);
   endtask
   task automatic t_power_up;
      chk("reset state", `BST_ST_RESET, state);
      chk("reset enable", 1'b1, oe_n);
      chk("reset preload", 8'h80, preload);
      ctl_u.step(1'b0, 1'b1, o, e);
      scan(1'b0, 32, 32'h0, d);
      chk("id code", 32'h1, d);
   endtask
   // Bypass and every unused code: 01 capture, zero then one-bit delay
   task automatic t_ir_codes;
      logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
      foreach (codes[k]) begin
         scan(1'b1, 3, {29'h0, codes[k]}, d);
         chk("ir capture", 2'h1, d[1:0]);
         scan(1'b0, 4, 32'hb, d);
         chk("bypass path", 32'h6, d);
      end
   endtask
   // Sample/preload, extest and sample-Z capture the ring and latch the preload
   task automatic t_ring;
      logic [2:0] ops [3] = '{3'h4, 3'h0, 3'h2};
      foreach (ops[k]) begin
         ring = 8'h5a ^ {5'h0, ops[k]};
         scan(1'b1, 3, {29'h0, ops[k]}, d);
         scan(1'b0, 8, 32'h3c, d);
         chk("ring capture", {24'h0, ring}, d);
         chk("preload", 8'h3c, preload);
         chk("extest", ops[k] == 3'h0, extest);
         chk("bus float", ops[k] != 3'h4, hiz);
      end
   endtask
   // Floating mode-select reads high: five rises from shift reach reset
   task automatic t_pull_reset;
      ctl_u.step(1'b1, 1'b1, o, e);
      ctl_u.step(1'b0, 1'b1, o, e);
      ctl_u.step(1'b0, 1'b1, o, e);
      tms_pull = 1'b1;
      repeat (4) ctl_u.step(1'b0, 1'b0, o, e);
      chk("fourth high rise", `BST_ST_SEL_IR, state);
      ctl_u.step(1'b0, 1'b0, o, e);
      chk("fifth high rise", `BST_ST_RESET, state);
      chk("float after reset", 1'b0, hiz);
      tms_pull = 1'b0;
      tdi_pull = 1'b1;
      ctl_u.step(1'b0, 1'b0, o, e);
      scan(1'b0, 32, 32'h0, d);
      chk("id after reset", 32'h1, d);
      scan(1'b1, 3, 32'h0, d);
      scan(1'b0, 2, 32'h0, d);
      chk("floating serial in", 32'h2, d);
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      t_power_up();
      t_ir_codes();
      t_ring();
      t_pull_reset();
      results();
   end
   // Cut a hang short
   initial begin
      #1000000;
      fail_count++;
      results();
   end
endmodule // sram_boundary_scan_tap_tb_top
